/* File: inc/sipo_map.svh */
/*
 * constants for the serial-in parallel-out latch: widths, depths, field bits.
 * assumes inclusion by bare name from the design files; definitions only.
 */
`ifndef SIPO_MAP_SVH
`define SIPO_MAP_SVH

// ==========================================================
// widths and depths
`define SIPO_STAGES      8
`define SIPO_LAST        7
`define SIPO_EVT_W       2
`define SIPO_FIFO_DEPTH  32
`define SIPO_PTR_W       5
`define SIPO_CNT_W       6
`define SIPO_PIN_W       4

// ==========================================================
// event word fields
`define SIPO_EVT_KIND    1
`define SIPO_EVT_DATA    0

// ==========================================================
// synchronised pin bits
`define SIPO_PIN_SCLK    0
`define SIPO_PIN_DATA    1
`define SIPO_PIN_STB     2
`define SIPO_PIN_OE      3

// ==========================================================
// reset values
`define SIPO_RST_BYTE    8'h00
`define SIPO_RST_BIT     1'h0

`endif

/* File: inc/sipo_pkg.sv */
/*
 * types for the serial-in parallel-out latch.
 * assumes sipo_map.svh is on the include path.
 */
`include "sipo_map.svh"

package sipo_pkg;

    // ==========================================================
    // shift clock edge kind carried in each event
    typedef enum logic {
        SIPO_EDGE_FALL,
        SIPO_EDGE_RISE
    } sipo_edge_t;

    typedef logic [`SIPO_STAGES-1:0] sipo_byte_t;
    typedef logic [`SIPO_EVT_W-1:0]  sipo_evt_t;

endpackage

/* File: design/sipo_sync.sv */
/*
 * two-flop synchroniser bank for asynchronous pin inputs.
 * assumes one system clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps

module sipo_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // pins and synchronised levels
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    // ==========================================================
    // per-bit two-stage chain
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic meta_r;
            logic stab_r;
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    meta_r <= 1'b0;
                    stab_r <= 1'b0;
                end else begin
                    meta_r <= async_i[g];
                    stab_r <= meta_r;
                end
            end
            assign sync_o[g] = stab_r;
        end
    endgenerate

endmodule

/* File: design/sipo_fifo.sv */
/*
 * synchronous fifo with valid/ready on both sides.
 * assumes one clock; depth is a power of two matching the pointer width.
 */
`timescale 1ns/1ps

module sipo_fifo #(
    parameter int W     = 2,
    parameter int DEPTH = 32,
    parameter int PTR_W = 5
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // fill side
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    // drain side
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic      [W-1:0] out_data_o
);

    logic [W-1:0]   mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [PTR_W:0]   count_r;
    logic             push;
    logic             pop;

    // ==========================================================
    // handshakes
    assign in_ready_o  = (count_r != DEPTH[PTR_W:0]);
    assign out_valid_o = (count_r != '0);
    assign out_data_o  = mem[rd_ptr_r];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // ==========================================================
    // storage
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data_i;
        end
    end

    // ==========================================================
    // pointers and fill count
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

endmodule

/* File: design/sipo_top.sv */
/*
 * serial-in parallel-out shift register with strobed latch and
 * three-state parallel outputs.
 * assumes shift clock, data, strobe and enable arrive as asynchronous
 * pins sampled by the 10 MHz system clock; drain_hold_i is same-clock.
 */
`timescale 1ns/1ps
`include "sipo_map.svh"

module sipo_top (
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    // pins from the controller
    input  wire logic                    shift_clk_i,
    input  wire logic                    ser_data_i,
    input  wire logic                    strobe_i,
    input  wire logic                    out_en_i,
    // local stall of the event drain
    input  wire logic                    drain_hold_i,
    // serial outputs
    output logic                         ser_fast_o,
    output logic                         ser_dly_o,
    // three-state parallel outputs
    output logic [`SIPO_STAGES-1:0]      par_o,
    output logic [`SIPO_STAGES-1:0]      par_oe_o,
    // status
    output logic                         evt_busy_o,
    output logic                         overrun_o
);

    // ==========================================================
    // declarations
    logic [`SIPO_PIN_W-1:0]  pins_async;
    logic [`SIPO_PIN_W-1:0]  pins_sync;
    logic                    sclk_prev_r;
    logic                    sclk_rise;
    logic                    sclk_fall;
    sipo_pkg::sipo_evt_t     evt_in;
    logic                    evt_in_valid;
    logic                    evt_in_ready;
    sipo_pkg::sipo_evt_t     evt_out;
    logic                    evt_out_valid;
    logic                    evt_pop;
    sipo_pkg::sipo_edge_t    evt_kind;
    sipo_pkg::sipo_byte_t    stage_r;
    sipo_pkg::sipo_byte_t    stage_nxt;
    sipo_pkg::sipo_byte_t    latch_r;
    logic                    fast_r;
    logic                    dly_r;
    logic                    oe_r;
    logic                    busy_r;
    logic                    overrun_r;

    // ==========================================================
    // edge kind decode
    function automatic sipo_pkg::sipo_edge_t evt_kind_of(input sipo_pkg::sipo_evt_t e);
        evt_kind_of = e[`SIPO_EVT_KIND] ? sipo_pkg::SIPO_EDGE_RISE
                                        : sipo_pkg::SIPO_EDGE_FALL;
    endfunction

    // ==========================================================
    // pin synchronisers
    assign pins_async = {out_en_i, strobe_i, ser_data_i, shift_clk_i};

    sipo_sync #(
        .W       (`SIPO_PIN_W)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (pins_async),
        .sync_o  (pins_sync)
    );

    // ==========================================================
    // shift clock edge detection
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_prev_r <= 1'b0;
        end else begin
            sclk_prev_r <= pins_sync[`SIPO_PIN_SCLK];
        end
    end

    assign sclk_rise = pins_sync[`SIPO_PIN_SCLK] && !sclk_prev_r;
    assign sclk_fall = !pins_sync[`SIPO_PIN_SCLK] && sclk_prev_r;

    // rising events carry the data bit sampled with the edge
    assign evt_in_valid = sclk_rise || sclk_fall;
    assign evt_in       = {sclk_rise, pins_sync[`SIPO_PIN_DATA]};

    // ==========================================================
    // event buffer
    sipo_fifo #(
        .W           (`SIPO_EVT_W),
        .DEPTH       (`SIPO_FIFO_DEPTH),
        .PTR_W       (`SIPO_PTR_W)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (evt_in_valid),
        .in_ready_o  (evt_in_ready),
        .in_data_i   (evt_in),
        .out_valid_o (evt_out_valid),
        .out_ready_i (!drain_hold_i),
        .out_data_o  (evt_out)
    );

    assign evt_pop  = evt_out_valid && !drain_hold_i;
    assign evt_kind = evt_kind_of(evt_out);

    // ==========================================================
    // shift register stages
    always_comb begin
        stage_nxt = {stage_r[`SIPO_LAST-1:0], evt_out[`SIPO_EVT_DATA]};
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stage_r <= `SIPO_RST_BYTE;
        end else if (evt_pop && evt_kind == sipo_pkg::SIPO_EDGE_RISE) begin
            stage_r <= stage_nxt;
        end
    end

    // ==========================================================
    // serial outputs
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            fast_r <= `SIPO_RST_BIT;
        end else if (evt_pop && evt_kind == sipo_pkg::SIPO_EDGE_RISE) begin
            fast_r <= stage_r[`SIPO_LAST-1];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dly_r <= `SIPO_RST_BIT;
        end else if (evt_pop && evt_kind == sipo_pkg::SIPO_EDGE_FALL) begin
            dly_r <= fast_r;
        end
    end

    // ==========================================================
    // storage latch
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            latch_r <= `SIPO_RST_BYTE;
        end else if (pins_sync[`SIPO_PIN_STB]) begin
            latch_r <= stage_r;
        end
    end

    // ==========================================================
    // output enable
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            oe_r <= 1'b0;
        end else begin
            oe_r <= pins_sync[`SIPO_PIN_OE];
        end
    end

    // ==========================================================
    // buffer status
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_r    <= 1'b0;
            overrun_r <= 1'b0;
        end else begin
            busy_r <= evt_out_valid;
            if (evt_in_valid && !evt_in_ready) begin
                overrun_r <= 1'b1;
            end
        end
    end

    // ==========================================================
    // outputs
    assign ser_fast_o = fast_r;
    assign ser_dly_o  = dly_r;
    assign par_o      = latch_r;
    assign par_oe_o   = {`SIPO_STAGES{oe_r}};
    assign evt_busy_o = busy_r;
    assign overrun_o  = overrun_r;

endmodule

/* File: tb/sipo_top_checker.sv */
/* assertions on the sipo_top ports.
   assumes one clock, async active-high reset, bind below. */
`timescale 1ns/1ps
`include "sipo_map.svh"

module sipo_top_checker (
    input wire logic                    clk_i,
    input wire logic                    rst_i,
    input wire logic                    shift_clk_i,
    input wire logic                    ser_data_i,
    input wire logic                    strobe_i,
    input wire logic                    out_en_i,
    input wire logic                    drain_hold_i,
    input wire logic                    ser_fast_o,
    input wire logic                    ser_dly_o,
    input wire logic [`SIPO_STAGES-1:0] par_o,
    input wire logic [`SIPO_STAGES-1:0] par_oe_o,
    input wire logic                    evt_busy_o,
    input wire logic                    overrun_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================================
    // sequences
    sequence s_oe_on;  out_en_i [*4]; endsequence
    sequence s_oe_off; !out_en_i [*4]; endsequence
    sequence s_stb_lo; !strobe_i [*5]; endsequence
    sequence s_lo_idle; (!shift_clk_i && !drain_hold_i && !evt_busy_o) [*6]; endsequence
    sequence s_hi_idle; (shift_clk_i && !drain_hold_i && !evt_busy_o) [*6]; endsequence
    // ==========================================================
    // properties
    chk_oe_on_drive: assert property (s_oe_on |-> par_oe_o == 8'hFF)
        else $error("outputs not driven");
    chk_oe_off_float: assert property (s_oe_off |-> par_oe_o == 8'h00)
        else $error("outputs not released");
    chk_oe_uniform: assert property (par_oe_o == 8'h00 || par_oe_o == 8'hFF)
        else $error("enables differ");
    chk_latch_holds: assert property (s_stb_lo |=> $stable(par_o))
        else $error("latch moved");
    chk_dly_copy: assert property ($changed(ser_dly_o) |-> ser_dly_o == ser_fast_o)
        else $error("delayed not a copy");
    chk_one_edge: assert property ($changed(ser_fast_o) |-> $stable(ser_dly_o))
        else $error("both serial outs moved");
    chk_fast_quiet: assert property (s_lo_idle |=> $stable(ser_fast_o))
        else $error("fast moved without rise");
    chk_dly_quiet: assert property (s_hi_idle |=> $stable(ser_dly_o))
        else $error("delayed moved without fall");
endmodule

bind sipo_top sipo_top_checker chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .shift_clk_i(shift_clk_i), .ser_data_i(ser_data_i),
    .strobe_i(strobe_i), .out_en_i(out_en_i), .drain_hold_i(drain_hold_i),
    .ser_fast_o(ser_fast_o), .ser_dly_o(ser_dly_o), .par_o(par_o), .par_oe_o(par_oe_o),
    .evt_busy_o(evt_busy_o), .overrun_o(overrun_o)
);

/* File: tb/sipo_ctrl_model.sv */
/* controller model driving the shift clock, data, strobe and enable pins.
   assumes callers enter its tasks just after a clock edge. */
`timescale 1ns/1ps

module sipo_ctrl_model (
    // clock
    input  wire logic clk_i,
    // pins
    output logic      shift_clk_o,
    output logic      ser_data_o,
    output logic      strobe_o,
    output logic      out_en_o
);
    initial begin
        shift_clk_o = 1'b0;
        ser_data_o  = 1'b0;
        strobe_o    = 1'b1;
        out_en_o    = 1'b1;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #10;
    endtask
    // data set up ahead, then spoiled once hold ends
    task automatic rise(input logic b);
        ser_data_o  = b;
        step(3);
        shift_clk_o = 1'b1;
        step(1);
        ser_data_o  = ~b;
        step(2);
    endtask
    task automatic fall();
        shift_clk_o = 1'b0;
        step(3);
    endtask
    task automatic send(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            rise(v[i]);
            fall();
        end
    endtask
    task automatic ctl(input logic stb, input logic oe);
        strobe_o = stb;
        out_en_o = oe;
        step(4);
    endtask
endmodule

/* File: tb/tb_sipo_top.sv */
/* self-checking bench for sipo_top.
   assumes the checker bind and the controller model are compiled. */
`timescale 1ns/1ps

module tb_sipo_top;
    logic       clk_i, rst_i, drain_hold_i;
    logic       shift_clk_i, ser_data_i, strobe_i, out_en_i;
    logic       ser_fast_o, ser_dly_o, evt_busy_o, overrun_o;
    logic [7:0] par_o, par_oe_o;
    int         fails = 0;
    int         compares = 0;

    sipo_top dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .shift_clk_i(shift_clk_i), .ser_data_i(ser_data_i),
        .strobe_i(strobe_i), .out_en_i(out_en_i), .drain_hold_i(drain_hold_i),
        .ser_fast_o(ser_fast_o), .ser_dly_o(ser_dly_o), .par_o(par_o), .par_oe_o(par_oe_o),
        .evt_busy_o(evt_busy_o), .overrun_o(overrun_o)
    );
    sipo_ctrl_model ctrl_u (
        .clk_i(clk_i), .shift_clk_o(shift_clk_i), .ser_data_o(ser_data_i),
        .strobe_o(strobe_i), .out_en_o(out_en_i)
    );

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // ==========================================================
    // helpers
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
        #10;
    endtask
    task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t byte %h exp %h", $time, g, e);
        end
    endtask
    task automatic cmp1(input logic g, input logic e);
        compares++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t bit %b exp %b", $time, g, e);
        end
    endtask
    task automatic summarize();
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_shift();
        ctrl_u.ctl(1'b1, 1'b1);
        ctrl_u.send(8'hA5);
        wt(8);
        cmp8(par_o, 8'hA5);
        cmp8(par_oe_o, 8'hFF);
        cmp1(ser_fast_o, 1'b1);
        cmp1(ser_dly_o, 1'b1);
    endtask
    task automatic t_hold();
        ctrl_u.ctl(1'b0, 1'b0);
        ctrl_u.send(8'h4B);
        wt(8);
        cmp8(par_o, 8'hA5);
        cmp8(par_oe_o, 8'h00);
        cmp1(ser_fast_o, 1'b0);
        ctrl_u.ctl(1'b1, 1'b1);
        wt(2);
        cmp8(par_o, 8'h4B);
    endtask
    // long high phase lets the delayed-output quiet check engage
    task automatic t_half();
        ctrl_u.rise(1'b1);
        wt(8);
        cmp1(ser_fast_o, 1'b1);
        cmp1(ser_dly_o, 1'b0);
        ctrl_u.fall();
        wt(3);
        cmp1(ser_dly_o, 1'b1);
        cmp8(par_o, 8'h97);
    endtask
    task automatic t_full();
        drain_hold_i = 1'b1;
        for (int i = 0; i < 20; i++) begin
            ctrl_u.rise(1'b0);
            ctrl_u.fall();
        end
        wt(4);
        cmp1(overrun_o, 1'b1);
        cmp1(evt_busy_o, 1'b1);
        drain_hold_i = 1'b0;
        wt(40);
        cmp1(evt_busy_o, 1'b0);
        cmp1(overrun_o, 1'b1);
    endtask

    initial begin
        rst_i        = 1'b1;
        drain_hold_i = 1'b0;
        repeat (6) @(posedge clk_i);
        #10;
        rst_i = 1'b0;
        wt(1);
        t_shift();
        t_hold();
        t_half();
        t_full();
        summarize();
    end
    initial begin
        repeat (3000) @(posedge clk_i);
        fails++;
        summarize();
    end
endmodule
